// File: rtl/mmce_consts.vh
// Constants for the move, coprocessor transfer and multiply execution block.
// Assumes a 32-bit datapath and one processor clock.
`ifndef MMCE_CONSTS_VH
`define MMCE_CONSTS_VH
// Operation codes on OP_SEL.
`define MMCE_OP_MOVE 2'h0
`define MMCE_OP_CPXFER 2'h1
`define MMCE_OP_MUL 2'h2
// Shift kinds on SHIFT_KIND.
`define MMCE_SH_ASL 3'h0
`define MMCE_SH_LSL 3'h1
`define MMCE_SH_LSR 3'h2
`define MMCE_SH_ASR 3'h3
`define MMCE_SH_ROR 3'h4
`define MMCE_SH_RRX 3'h5
// Status word layout of the program counter register.
`define MMCE_PSR_N 31
`define MMCE_PSR_Z 30
`define MMCE_PSR_C 29
`define MMCE_PSR_V 28
`define MMCE_PC_MASK 32'h03fffffc
`define MMCE_PC_REG 4'hf
`define MMCE_PC_OFS_RM 32'h0000000c
`define MMCE_PC_OFS_RS 32'h00000008
// Booth radix-4 consumes two multiplier bits per clock.
`define MMCE_MUL_MAX_CLK 5'h10
`endif

// File: rtl/mmce_exec.v
// Execution logic for register move, CPU-to-coprocessor transfer and multiply.
// Assumes decode supplies operands one cycle with START high, and waits on BUSY.
// How it works
// RQ1 - Move writes the evaluated second operand into the destination.
// RQ2 - Move with flag update sets N, Z and C from the moved operand.
// RQ3 - Shift count from register 1 to 32, or immediate 1 to 31.
// RQ4 - Shifts ASL, LSL, LSR, ASR, ROR, and one-bit rotate through carry.
// RQ5 - Immediate operand is an 8-bit value with a rotation.
// RQ6 - The 8-bit constant is rotated back into position at execution.
// RQ7 - Negative constants are encoded by the program generator as complement moves.
// RQ8 - Flag-updating move of link register into PC restores PC and status.
// RQ9 - Coprocessor transfer drives register and control fields, flags unchanged.
// RQ10 - Interface carries two coprocessor register fields, data, select, action, auxiliary.
// RQ11 - Select number 0 to 15 picks the coprocessor; other fields conventional.
// RQ12 - Multiply two 32-bit registers, keep the low 32 bits.
// RQ13 - Booth multiply, at most 16 clocks, early exit on clear upper bits.
// RQ14 - Low-order product is correct whatever the operand signs.
// RQ15 - Software keeps destination apart from multiplicand and off the PC.
// RQ16 - Addend field of plain multiply is encoded as zero.
// RQ17 - Multiply flag update sets N and Z, C undefined, V kept.
// RQ18 - PC as multiplicand includes flags and is offset by 12.
// RQ19 - PC as multiplier excludes flags and is offset by 8.
// RQ20 - Pipeline stalls until the product is done; write happens in one cycle.
//
// The plain strobed port and the register addresses were left to the implementer.
`include "mmce_consts.vh"
module mmce_exec (
    input wire CLK,
    input wire RST_B,
    input wire START,
    input wire COND_PASS,
    input wire [1:0] OP_SEL,
    input wire SET_FLAGS,
    input wire [3:0] DEST_IDX,
    input wire [3:0] MCAND_IDX,
    input wire [3:0] MPLIER_IDX,
    input wire [3:0] ADDEND_FIELD,
    input wire [31:0] MCAND_VAL,
    input wire [31:0] SHIFT_VAL,
    input wire [31:0] PC_PSR,
    input wire USE_IMM,
    input wire [7:0] IMM_BYTE,
    input wire [3:0] IMM_ROT,
    input wire [2:0] SHIFT_KIND,
    input wire SHIFT_BY_REG,
    input wire [4:0] SHIFT_IMM,
    input wire [3:0] CP_SELECT,
    input wire [2:0] CP_ACTION,
    input wire [2:0] CP_AUX,
    input wire [3:0] CP_REG_A,
    input wire [3:0] CP_REG_B,
    output reg BUSY,
    output reg WR_EN,
    output reg [3:0] WR_IDX,
    output reg [31:0] WR_DATA,
    output reg FLAGS_EN,
    output reg [3:0] FLAGS_NZCV,
    output reg PSR_EN,
    output reg [31:0] PSR_DATA,
    output reg CP_VALID,
    output reg [31:0] CP_DATA,
    output reg [3:0] CP_SEL,
    output reg [2:0] CP_OPC,
    output reg [2:0] CP_INFO,
    output reg [3:0] CP_CRA,
    output reg [3:0] CP_CRB,
    output reg ENC_ERR
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_MUL = 2'b10;

    // ------------------------------------------------------------
    // Sequencer and multiplier state
    // ------------------------------------------------------------
    // Operands are latched at START; the operand inputs are ignored until BUSY falls.
    reg [1:0] state_ff;
    reg [31:0] acc_ff;
    reg [31:0] mcand_ff;
    reg [32:0] mplier_ff;
    reg [4:0] clk_cnt_ff;
    reg [3:0] dest_ff;
    reg sflag_ff;
    reg vflag_ff;

    // ------------------------------------------------------------
    // Second operand: shifter and constant expansion
    // ------------------------------------------------------------
    wire carry_in = PC_PSR[`MMCE_PSR_C];
    // The PC as a move source reads with the same +12 offset as the multiplicand.
    wire [31:0] mv_src = (MCAND_IDX == `MMCE_PC_REG) ? PC_PSR + `MMCE_PC_OFS_RM : MCAND_VAL;
    // Only the low byte of the count register is used; larger counts behave as 32.
    // At 32 every bit has left the word except under ROR, which leaves it unchanged; the carry is the last bit out.
    wire [5:0] reg_cnt = (SHIFT_VAL[7:0] > 8'h20) ? 6'h20 : SHIFT_VAL[5:0];
    wire [5:0] sh_cnt = SHIFT_BY_REG ? reg_cnt : {1'b0, SHIFT_IMM}; // [RQ3]
    // The byte is doubled so that a plain right shift gives a rotate of the byte.
    wire [63:0] imm_dbl = {24'h000000, IMM_BYTE, 24'h000000, IMM_BYTE};
    wire [4:0] imm_amt = {IMM_ROT, 1'b0};
    wire [63:0] imm_sh = imm_dbl >> imm_amt;
    wire [63:0] ror_dbl = {mv_src, mv_src} >> sh_cnt[4:0];
    wire [63:0] sext = {{32{mv_src[31]}}, mv_src};
    wire [63:0] asr_sh = sext >> sh_cnt;
    wire [63:0] lsl_sh = {32'h00000000, mv_src} << sh_cnt;
    wire [63:0] lsr_sh = {mv_src, 32'h00000000} >> sh_cnt;
    reg [31:0] op2;
    reg op2_c;

    always @* begin
        op2 = mv_src;
        op2_c = carry_in;
        if (USE_IMM) begin
            op2 = imm_sh[31:0]; // [RQ5] [RQ6]
            if (IMM_ROT != 4'h0) begin
                op2_c = imm_sh[31];
            end
        end else if (SHIFT_KIND == `MMCE_SH_RRX) begin
            op2 = {carry_in, mv_src[31:1]}; // [RQ4]
            op2_c = mv_src[0];
        end else if (sh_cnt != 6'h00) begin
            case (SHIFT_KIND) // [RQ4]
                `MMCE_SH_ASL, `MMCE_SH_LSL: begin
                    op2 = lsl_sh[31:0];
                    op2_c = lsl_sh[32];
                end
                `MMCE_SH_LSR: begin
                    op2 = lsr_sh[63:32];
                    op2_c = lsr_sh[31];
                end
                `MMCE_SH_ASR: begin
                    op2 = asr_sh[31:0];
                    op2_c = sh_cnt[5] ? mv_src[31] : sext[sh_cnt - 6'h01];
                end
                `MMCE_SH_ROR: begin
                    op2 = ror_dbl[31:0];
                    op2_c = ror_dbl[31];
                end
                default: begin
                    op2 = mv_src;
                    op2_c = carry_in;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Multiplier operand selection and Booth step
    // ------------------------------------------------------------
    // The PC as multiplicand keeps its flags; as multiplier it is masked.
    wire [31:0] mul_a = (MCAND_IDX == `MMCE_PC_REG) ? PC_PSR + `MMCE_PC_OFS_RM : MCAND_VAL; // [RQ18]
    wire [31:0] mul_b = (MPLIER_IDX == `MMCE_PC_REG) ?
        (PC_PSR & `MMCE_PC_MASK) + `MMCE_PC_OFS_RS : SHIFT_VAL; // [RQ19]
    reg [31:0] booth_add;

    // Each overlapping triple of multiplier bits selects 0, +-1 or +-2 times the multiplicand.
    always @* begin
        case (mplier_ff[2:0]) // [RQ13]
            3'b001, 3'b010: begin
                booth_add = mcand_ff;
            end
            3'b011: begin
                booth_add = {mcand_ff[30:0], 1'b0};
            end
            3'b100: begin
                booth_add = ~{mcand_ff[30:0], 1'b0} + 32'h00000001;
            end
            3'b101, 3'b110: begin
                booth_add = ~mcand_ff + 32'h00000001;
            end
            default: begin
                booth_add = 32'h00000000;
            end
        endcase
    end

    wire [31:0] acc_next = acc_ff + booth_add;
    // Only the low 32 bits matter, so the multiplier is treated as unsigned-extended
    // with wraparound; that is exact modulo 2^32 for any mix of signs.
    wire [32:0] mpl_shift = {2'b00, mplier_ff[32:2]};
    wire [31:0] mcand_next = {mcand_ff[29:0], 2'b00};
    // A negative digit leaves a single borrow bit behind that still needs one more
    // step, so the early exit waits until every multiplier bit has cleared.
    wire mpl_done = (mpl_shift == 33'h000000000);
    wire cnt_done = (clk_cnt_ff == `MMCE_MUL_MAX_CLK - 5'h01);
    wire mul_last = mpl_done || cnt_done; // [RQ13]

    // ------------------------------------------------------------
    // Flag words
    // ------------------------------------------------------------
    // V is never produced here and passes through from the status word.
    wire op2_zero = (op2 == 32'h00000000);
    wire acc_zero = (acc_next == 32'h00000000);
    wire [3:0] move_flags = {op2[31], op2_zero, op2_c, PC_PSR[`MMCE_PSR_V]}; // [RQ2]
    // Carry after a multiply is undefined, so it is written as zero for repeatable results.
    wire [3:0] mul_flags = {acc_next[31], acc_zero, 1'b0, vflag_ff}; // [RQ17]

    // ------------------------------------------------------------
    // Control and result registers
    // ------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            // Strobes clear on reset so no stale write follows the release.
            state_ff <= ST_IDLE;
            acc_ff <= 32'h00000000;
            mcand_ff <= 32'h00000000;
            mplier_ff <= 33'h000000000;
            clk_cnt_ff <= 5'h00;
            dest_ff <= 4'h0;
            sflag_ff <= 1'b0;
            vflag_ff <= 1'b0;
            BUSY <= 1'b0;
            WR_EN <= 1'b0;
            WR_IDX <= 4'h0;
            WR_DATA <= 32'h00000000;
            FLAGS_EN <= 1'b0;
            FLAGS_NZCV <= 4'h0;
            PSR_EN <= 1'b0;
            PSR_DATA <= 32'h00000000;
            CP_VALID <= 1'b0;
            CP_DATA <= 32'h00000000;
            CP_SEL <= 4'h0;
            CP_OPC <= 3'h0;
            CP_INFO <= 3'h0;
            CP_CRA <= 4'h0;
            CP_CRB <= 4'h0;
            ENC_ERR <= 1'b0;
        end else begin
            // Every strobe is a one-cycle pulse; the data fields hold until the next write.
            WR_EN <= 1'b0;
            FLAGS_EN <= 1'b0;
            PSR_EN <= 1'b0;
            CP_VALID <= 1'b0;
            ENC_ERR <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (START && COND_PASS) begin
                        case (OP_SEL)
                            `MMCE_OP_MOVE: begin
                                WR_EN <= 1'b1; // [RQ1]
                                WR_IDX <= DEST_IDX;
                                WR_DATA <= op2;
                                if (SET_FLAGS) begin
                                    FLAGS_EN <= 1'b1; // [RQ2]
                                    FLAGS_NZCV <= move_flags;
                                    if (DEST_IDX == `MMCE_PC_REG) begin
                                        // Status returns from the moved word, so flags follow it.
                                        FLAGS_EN <= 1'b0;
                                        PSR_EN <= 1'b1; // [RQ8]
                                        PSR_DATA <= op2;
                                    end
                                end
                            end
                            `MMCE_OP_CPXFER: begin
                                // Only the select number matters to hardware; other fields pass as given.
                                // No flag strobe is raised, so the flags stay as they were.
                                CP_VALID <= 1'b1; // [RQ9]
                                CP_DATA <= mv_src; // [RQ10]
                                CP_SEL <= CP_SELECT; // [RQ11]
                                CP_OPC <= CP_ACTION;
                                CP_INFO <= CP_AUX;
                                CP_CRA <= CP_REG_A;
                                CP_CRB <= CP_REG_B;
                            end
                            `MMCE_OP_MUL: begin
                                state_ff <= ST_MUL;
                                BUSY <= 1'b1; // [RQ20]
                                acc_ff <= 32'h00000000;
                                mcand_ff <= mul_a; // [RQ12]
                                mplier_ff <= {mul_b, 1'b0}; // [RQ14]
                                clk_cnt_ff <= 5'h00;
                                dest_ff <= DEST_IDX;
                                sflag_ff <= SET_FLAGS;
                                vflag_ff <= PC_PSR[`MMCE_PSR_V];
                                // Nonzero addend field is flagged, the product still runs.
                                ENC_ERR <= (ADDEND_FIELD != 4'h0) || (DEST_IDX == `MMCE_PC_REG); // [RQ16] [RQ15]
                            end
                            default: begin
                                ENC_ERR <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_MUL: begin
                    // START is not looked at here; decode holds the next operation until BUSY falls.
                    acc_ff <= acc_next;
                    mcand_ff <= mcand_next;
                    mplier_ff <= mpl_shift;
                    clk_cnt_ff <= clk_cnt_ff + 5'h01;
                    if (mul_last) begin
                        state_ff <= ST_IDLE;
                        BUSY <= 1'b0; // [RQ20]
                        WR_EN <= 1'b1; // [RQ12]
                        WR_IDX <= dest_ff;
                        WR_DATA <= acc_next;
                        if (sflag_ff) begin
                            FLAGS_EN <= 1'b1; // [RQ17]
                            FLAGS_NZCV <= mul_flags;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    BUSY <= 1'b0;
                end
            endcase
        end
    end
endmodule // mmce_exec

// File: sim/mmce_exec_sva.sv
// Port-level checks for the execution block.
// Assumes one clock and the active-low asynchronous reset.
`include "mmce_consts.vh"
module mmce_exec_sva (
    input wire CLK,
    input wire RST_B,
    input wire START,
    input wire COND_PASS,
    input wire [1:0] OP_SEL,
    input wire [3:0] DEST_IDX,
    input wire [3:0] ADDEND_FIELD,
    input wire BUSY,
    input wire WR_EN,
    input wire [3:0] WR_IDX,
    input wire [31:0] WR_DATA,
    input wire FLAGS_EN,
    input wire [3:0] FLAGS_NZCV,
    input wire PSR_EN,
    input wire [31:0] PSR_DATA,
    input wire CP_VALID
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire take = START && COND_PASS && !BUSY;
    sequence s_mul_take;
        take && OP_SEL == `MMCE_OP_MUL && ADDEND_FIELD == 4'h0 && DEST_IDX != `MMCE_PC_REG;
    endsequence
    sequence s_mul_write;
        ##[2:17] (WR_EN && !BUSY);
    endsequence
    property p_mul_bound; s_mul_take |-> s_mul_write; endproperty
    a_mul_bound: assert property (p_mul_bound) else $error("multiply late");
    property p_mul_stall; s_mul_take |=> BUSY && !WR_EN; endproperty
    a_mul_stall: assert property (p_mul_stall) else $error("no stall");
    property p_busy_write; $fell(BUSY) |-> WR_EN; endproperty
    a_busy_write: assert property (p_busy_write) else $error("stall ends without write");
    property p_move; take && OP_SEL == `MMCE_OP_MOVE |=> WR_EN && WR_IDX == $past(DEST_IDX); endproperty
    a_move: assert property (p_move) else $error("move not written");
    property p_flags; FLAGS_EN |-> FLAGS_NZCV[3] == WR_DATA[31] && FLAGS_NZCV[2] == (WR_DATA == 32'h0); endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");
    property p_psr; PSR_EN |-> WR_EN && PSR_DATA == WR_DATA && !FLAGS_EN; endproperty
    a_psr: assert property (p_psr) else $error("status restore wrong");
    property p_cp; take && OP_SEL == `MMCE_OP_CPXFER |=> CP_VALID && !FLAGS_EN && !WR_EN; endproperty
    a_cp: assert property (p_cp) else $error("transfer wrong");
    property p_nocond; START && !COND_PASS && !BUSY |=> !WR_EN && !CP_VALID && !BUSY; endproperty
    a_nocond: assert property (p_nocond) else $error("false condition acted");
endmodule // mmce_exec_sva
bind mmce_exec mmce_exec_sva u_mmce_exec_sva (.CLK(CLK), .RST_B(RST_B), .START(START), .COND_PASS(COND_PASS),
    .OP_SEL(OP_SEL), .DEST_IDX(DEST_IDX), .ADDEND_FIELD(ADDEND_FIELD), .BUSY(BUSY), .WR_EN(WR_EN),
    .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .FLAGS_EN(FLAGS_EN), .FLAGS_NZCV(FLAGS_NZCV), .PSR_EN(PSR_EN),
    .PSR_DATA(PSR_DATA), .CP_VALID(CP_VALID));

// File: sim/mmce_cop_model.sv
// Coprocessor model on the transfer side of the block.
// Assumes the strobe and fields are registered by the block.
module mmce_cop_model #(
    parameter [3:0] MY_NUM = 4'h3
) (
    input wire clk,
    input wire rst_b,
    input wire cp_valid,
    input wire [3:0] cp_sel,
    input wire [2:0] cp_opc,
    input wire [31:0] cp_data,
    output logic [7:0] hit_cnt,
    output logic [34:0] last_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only the select number decides whether this unit takes a word.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hit_cnt <= 8'h0;
            last_word <= 35'h0;
        end else if (cp_valid && cp_sel == MY_NUM) begin
            hit_cnt <= hit_cnt + 8'h1;
            last_word <= {cp_opc, cp_data};
        end
    end
endmodule // mmce_cop_model

// File: sim/move_multiply_coproc_exec_bench.sv
// Self-checking bench for the execution block with a coprocessor model.
// Assumes a 25 MHz clock and the block's header on the include path.
`include "mmce_consts.vh"
module move_multiply_coproc_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Row: kind, by-reg, imm count, count reg, use imm, byte, rotate, carry in, result, carry out.
    logic [87:0] rows [10] = '{
        {3'h1,1'b0,5'h04,32'h00,1'b0,8'h00,4'h0,1'b0,32'h00000030,1'b0},
        {3'h0,1'b0,5'h01,32'h00,1'b0,8'h00,4'h0,1'b0,32'h00000006,1'b1},
        {3'h2,1'b0,5'h01,32'h00,1'b0,8'h00,4'h0,1'b0,32'h40000001,1'b1},
        {3'h3,1'b0,5'h1f,32'h00,1'b0,8'h00,4'h0,1'b0,32'hffffffff,1'b0},
        {3'h4,1'b0,5'h04,32'h00,1'b0,8'h00,4'h0,1'b0,32'h38000000,1'b0},
        {3'h5,1'b0,5'h00,32'h00,1'b0,8'h00,4'h0,1'b1,32'hc0000001,1'b1},
        {3'h2,1'b1,5'h00,32'h20,1'b0,8'h00,4'h0,1'b0,32'h00000000,1'b1},
        {3'h1,1'b1,5'h00,32'h21,1'b0,8'h00,4'h0,1'b0,32'h00000000,1'b1},
        {3'h1,1'b0,5'h00,32'h00,1'b1,8'h80,4'h0,1'b1,32'h00000080,1'b1},
        {3'h1,1'b0,5'h00,32'h00,1'b1,8'hff,4'h1,1'b0,32'hc000003f,1'b1}};
    logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, cond = 1'b1, sf = 1'b1, uimm = 1'b0, sbr = 1'b0;
    logic [1:0] op = 2'h0;
    logic [2:0] sk = 3'h0, cact = 3'h0, caux = 3'h0;
    logic [3:0] dst = 4'h1, mci = 4'h2, mpi = 4'h3, add = 4'h0, ir = 4'h0, csel = 4'h0, cra = 4'h0, crb = 4'h0;
    logic [4:0] shi = 5'h0;
    logic [7:0] ib = 8'h0;
    logic [31:0] mcv = 32'h80000003, shv = 32'h0, pcw = 32'h0;
    wire busy, wr_en, fl_en, psr_en, cp_v, enc;
    wire [3:0] wr_idx, fl, cp_s, cp_a, cp_b;
    wire [2:0] cp_o, cp_i;
    wire [31:0] wr_data, psr_data, cp_d;
    wire [7:0] cop_n;
    wire [34:0] cop_w;
    int error_cnt = 0, total_checks = 0;
    mmce_exec u_mmce_exec (.CLK(clk), .RST_B(rst_b), .START(start), .COND_PASS(cond), .OP_SEL(op),
        .SET_FLAGS(sf), .DEST_IDX(dst), .MCAND_IDX(mci), .MPLIER_IDX(mpi), .ADDEND_FIELD(add), .MCAND_VAL(mcv),
        .SHIFT_VAL(shv), .PC_PSR(pcw), .USE_IMM(uimm), .IMM_BYTE(ib), .IMM_ROT(ir), .SHIFT_KIND(sk),
        .SHIFT_BY_REG(sbr), .SHIFT_IMM(shi), .CP_SELECT(csel), .CP_ACTION(cact), .CP_AUX(caux), .CP_REG_A(cra),
        .CP_REG_B(crb), .BUSY(busy), .WR_EN(wr_en), .WR_IDX(wr_idx), .WR_DATA(wr_data), .FLAGS_EN(fl_en),
        .FLAGS_NZCV(fl), .PSR_EN(psr_en), .PSR_DATA(psr_data), .CP_VALID(cp_v), .CP_DATA(cp_d), .CP_SEL(cp_s),
        .CP_OPC(cp_o), .CP_INFO(cp_i), .CP_CRA(cp_a), .CP_CRB(cp_b), .ENC_ERR(enc));
    mmce_cop_model #(.MY_NUM(4'h3)) u_mmce_cop_model (.clk(clk), .rst_b(rst_b), .cp_valid(cp_v), .cp_sel(cp_s),
        .cp_opc(cp_o), .cp_data(cp_d), .hit_cnt(cop_n), .last_word(cop_w));
    always #20 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic go(input logic [1:0] o);
        op <= o;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
    endtask
    task automatic mul(input logic [31:0] a, b, input logic [3:0] ci, pi, input logic [31:0] exp, input int maxn);
        int n;
        @(posedge clk);
        {add, dst, mcv, shv, mci, mpi} <= {4'h0, 4'h1, a, b, ci, pi};
        go(`MMCE_OP_MUL);
        for (n = 1; n < 40 && wr_en !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(wr_data, exp);
        chk({28'h0, wr_idx}, 32'h1);
        chk({31'h0, n <= maxn}, 32'h1);
        chk({28'h0, fl}, {28'h0, exp[31], exp == 32'h0, 1'b0, pcw[28]});
        if (n >= 40) summarize;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk({26'h0, busy, wr_en, fl_en, psr_en, cp_v, enc}, 32'h0);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            {sk, sbr, shi, shv, uimm, ib, ir, pcw[29]} <= rows[i][87:33];
            go(`MMCE_OP_MOVE);
            chk({30'h0, wr_en, fl_en}, 32'h3);
            chk(wr_data, rows[i][32:1]);
            chk({29'h0, fl[3:1]}, {29'h0, rows[i][32], rows[i][32:1] == 32'h0, rows[i][0]});
        end
        @(posedge clk);
        {dst, mci, mcv, uimm} <= {`MMCE_PC_REG, 4'he, 32'ha0000123, 1'b0};
        go(`MMCE_OP_MOVE);
        chk({29'h0, wr_en, psr_en, fl_en}, 32'h6);
        chk(psr_data, 32'ha0000123);
        for (int s = 3; s < 12; s += 5) begin
            @(posedge clk);
            {dst, mci, mcv, csel, cact, caux, cra, crb} <= {8'h14, 32'h5a5a0000 | s, s[3:0], 3'h6, 3'h5, 8'hf0};
            go(`MMCE_OP_CPXFER);
            chk({12'h0, cp_v, fl_en, cp_s, cp_o, cp_i, cp_a, cp_b}, {12'h0, 2'b10, s[3:0], 3'h6, 3'h5, 8'hf0});
            chk(cp_d, mcv);
        end
        chk({24'h0, cop_n}, 32'h1);
        chk(cop_w[31:0], 32'h5a5a0003);
        @(posedge clk);
        cond <= 1'b0;
        go(`MMCE_OP_CPXFER);
        chk({30'h0, cp_v, wr_en}, 32'h0);
        @(posedge clk);
        {cond, add, pcw} <= {1'b1, 4'h1, 32'h10000010};
        go(`MMCE_OP_MUL);
        chk({30'h0, enc, busy}, 32'h3);
        mul(32'h3, 32'h5, 4'h2, 4'h3, 32'hf, 3);
        mul(32'hfffffff9, 32'h6, 4'h2, 4'h3, 32'hffffffd6, 3);
        mul(32'hfffffff9, 32'hfffffffe, 4'h2, 4'h3, 32'he, 17);
        mul(32'h12345678, 32'hffffffff, 4'h2, 4'h3, 32'hedcba988, 17);
        mul(32'h0, 32'h7, 4'h2, 4'h3, 32'h0, 3);
        mul(32'h0, 32'h2, `MMCE_PC_REG, 4'h3, 32'h20000038, 3);
        mul(32'h3, 32'h0, 4'h2, `MMCE_PC_REG, 32'h48, 4);
        summarize;
    end
endmodule // move_multiply_coproc_exec_bench
